// *** verilog/irx_defines.svh ***
// Purpose: Constants for the isochronous receive pointer and match block.
// Assumes: Byte addresses on a 16-bit APB address, 32-bit data.
// Notes: Offsets, field positions and reset values live here; the bench repeats the offsets and the write mask as literals.
// Summary of operation
// - Each context has a read-only word holding its first descriptor address.
// - Four contexts 0 to 3 exist, their registers spaced 32 bytes apart.
// - The match word starts on a cycle, filters by tag and waits for a sync.
// - Bit 31 set accepts packets with tag 11.
// - Bit 30 set accepts packets with tag 10.
// - Bit 29 set accepts packets with tag 01.
// - Bit 28 set accepts packets with tag 00.
// - With cycle matching on, reception opens the cycle after the time equals bits 26-12.
// - Bits 11-8 are compared with the packet sync while SYNC_WAIT is set and no matching sync is seen yet.
// - Bit 6 with tag 01 enabled accepts tag 01 only when sync bits 3-2 are 0.
// - Bits 5-0 select the channel whose packets the context accepts.
`ifndef IRX_DEFINES_SVH
`define IRX_DEFINES_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define IRX_PTR_BASE 16'h040C
`define IRX_MATCH_BASE 16'h410C
`define IRX_CTX_MASK 16'h0060
`define IRX_CTX_MSB 6
`define IRX_CTX_LSB 5

// ----------------------------------------------------------------
// Match word layout and reset values
// ----------------------------------------------------------------
`define IRX_MATCH_WMASK 32'hF7FF_FF7F
`define IRX_MATCH_RST 32'h0000_0000
`define IRX_PTR_RST 32'h0000_0000
`define IRX_ACCEPT_TAG_ZERO_BIT 28
`define IRX_ACCEPT_TAG_ONE_BIT 29
`define IRX_ACCEPT_TAG_TWO_BIT 30
`define IRX_ACCEPT_TAG_THREE_BIT 31
`define IRX_RSVD_BIT 7
`define IRX_CYC_MSB 26
`define IRX_CYC_LSB 12
`define IRX_SYNC_MSB 11
`define IRX_SYNC_LSB 8
`define IRX_RSYNC_BIT 6
`define IRX_CHAN_MSB 5
`define IRX_CHAN_LSB 0
`define IRX_TAG_ONE 2'h1
`define IRX_TAG_TWO 2'h2
`define IRX_TAG_THREE 2'h3
`define IRX_TAG_ZERO 2'h0
`define IRX_SYNC_HI_OK 2'h0
`define IRX_SYNC_HI_MSB 3
`define IRX_SYNC_HI_LSB 2

`endif

// *** verilog/irx_pkg.sv ***
// Purpose: Shared types of the isochronous receive match block.
// Assumes: Four contexts.
// Notes: One buffered packet descriptor is one irx_pkt_t.
package irx_pkg;
  typedef logic [31:0] irx_word_t;
  typedef logic [3:0] irx_ctx_vec_t;
  typedef struct packed {
    logic [1:0] tag;
    logic [5:0] chan;
    logic [3:0] sync;
    logic [3:0] hit;
  } irx_pkt_t;
endpackage : irx_pkg

// *** verilog/irx_top.sv ***
// Purpose: Pointer and match registers of four isochronous receive
//   contexts, with the packet filter and a two-entry output buffer.
// Assumes: Packet, cycle time and descriptor inputs come from logic
//   on CLK, so they need no synchroniser.
// Notes: APB slave with one wait-free access phase.
`timescale 1ns/1ps
`include "irx_defines.svh"

module irx_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PTR_LOAD,
  input wire logic [1:0] PTR_CTX,
  input wire logic [31:0] PTR_ADDR,
  input wire logic [3:0] CYC_MATCH_EN,
  input wire logic [14:0] CYC_TIME,
  input wire logic [3:0] SYNC_WAIT,
  input wire logic PKT_VALID,
  output logic PKT_READY,
  input wire logic [1:0] PKT_TAG,
  input wire logic [5:0] PKT_CHAN,
  input wire logic [3:0] PKT_SYNC,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [1:0] OUT_TAG,
  output logic [5:0] OUT_CHAN,
  output logic [3:0] OUT_SYNC,
  output logic [3:0] OUT_CTX_HIT
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  irx_pkg::irx_word_t ptr_q [4];
  irx_pkg::irx_word_t ptr_d [4];
  irx_pkg::irx_word_t match_q [4];
  irx_pkg::irx_word_t match_d [4];
  irx_pkg::irx_word_t prdata_q;
  irx_pkg::irx_word_t prdata_d;
  irx_pkg::irx_word_t rd_word;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [1:0] ctx;
  logic [15:0] base;
  logic is_ptr;
  logic is_match;
  logic setup;
  logic access;

  assign ctx = PADDR[`IRX_CTX_MSB:`IRX_CTX_LSB];
  assign base = PADDR & ~`IRX_CTX_MASK;
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & pready_q;

  always_comb begin
    is_ptr = (base == `IRX_PTR_BASE);
    is_match = (base == `IRX_MATCH_BASE);
    rd_word = '0;
    if (is_ptr) begin
      rd_word = ptr_q[ctx];
    end else if (is_match) begin
      rd_word = match_q[ctx] & `IRX_MATCH_WMASK;
    end
    pready_d = setup;
    pslverr_d = setup & ~(is_ptr | is_match);
    prdata_d = setup ? rd_word : prdata_q;
  end

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      ptr_d[n] = ptr_q[n];
      match_d[n] = match_q[n];
    end
    if (PTR_LOAD) begin
      ptr_d[PTR_CTX] = PTR_ADDR;
    end
    if (access & PWRITE & is_match) begin
      match_d[ctx] = PWDATA & `IRX_MATCH_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int n = 0; n < 4; n++) begin
        ptr_q[n] <= `IRX_PTR_RST;
        match_q[n] <= `IRX_MATCH_RST;
      end
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        ptr_q[n] <= ptr_d[n];
        match_q[n] <= match_d[n];
      end
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  // ----------------------------------------------------------------
  // Packet filter
  // ----------------------------------------------------------------
  irx_pkg::irx_ctx_vec_t started_q;
  irx_pkg::irx_ctx_vec_t started_d;
  irx_pkg::irx_ctx_vec_t seen_q;
  irx_pkg::irx_ctx_vec_t seen_d;
  irx_pkg::irx_ctx_vec_t hit_vec;
  logic pkt_ready_q;
  logic acc;

  // Non-matching packets are still taken, then dropped, so one context
  // with no interest never stalls the link for the others.
  assign acc = PKT_VALID & pkt_ready_q;

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      hit_vec[n] = match_q[n][`IRX_ACCEPT_TAG_ZERO_BIT + PKT_TAG];
      if (match_q[n][`IRX_RSYNC_BIT] && PKT_TAG == `IRX_TAG_ONE &&
          PKT_SYNC[`IRX_SYNC_HI_MSB:`IRX_SYNC_HI_LSB] !=
          `IRX_SYNC_HI_OK) begin
        hit_vec[n] = 1'b0;
      end
      if (PKT_CHAN != match_q[n][`IRX_CHAN_MSB:`IRX_CHAN_LSB]) begin
        hit_vec[n] = 1'b0;
      end
      if (CYC_MATCH_EN[n] && !started_q[n]) begin
        hit_vec[n] = 1'b0;
      end
      // hold off until the sync value
      if (SYNC_WAIT[n] && !seen_q[n] &&
          PKT_SYNC != match_q[n][`IRX_SYNC_MSB:`IRX_SYNC_LSB]) begin
        hit_vec[n] = 1'b0;
      end
      started_d[n] = CYC_MATCH_EN[n] & (started_q[n] |
        (CYC_TIME == match_q[n][`IRX_CYC_MSB:`IRX_CYC_LSB]));
      seen_d[n] = SYNC_WAIT[n] & (seen_q[n] | (acc & hit_vec[n]));
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      started_q <= '0;
      seen_q <= '0;
    end else begin
      started_q <= started_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------
  irx_pkg::irx_pkt_t in_pkt;
  irx_pkg::irx_pkt_t head_q;
  irx_pkg::irx_pkt_t head_d;
  irx_pkg::irx_pkt_t skid_q;
  irx_pkg::irx_pkt_t skid_d;
  logic head_v_q;
  logic head_v_d;
  logic skid_v_q;
  logic skid_v_d;
  logic pkt_ready_d;
  logic push;
  logic pop;

  assign push = acc & (|hit_vec);
  assign pop = head_v_q & OUT_READY;

  always_comb begin
    in_pkt = '{tag: PKT_TAG, chan: PKT_CHAN, sync: PKT_SYNC, hit: hit_vec};
    head_d = head_q;
    head_v_d = head_v_q;
    skid_d = skid_q;
    skid_v_d = skid_v_q;
    if (!head_v_q || pop) begin
      if (skid_v_q) begin
        head_d = skid_q;
        head_v_d = 1'b1;
        skid_d = in_pkt;
        skid_v_d = push;
      end else begin
        head_d = in_pkt;
        head_v_d = push;
      end
    end else if (push) begin
      skid_d = in_pkt;
      skid_v_d = 1'b1;
    end
    // Ready is registered, so it must already refuse when a stall
    // would leave no room for one more word.
    pkt_ready_d = ~skid_v_d;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      head_q <= '0;
      skid_q <= '0;
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      pkt_ready_q <= 1'b0;
    end else begin
      head_q <= head_d;
      skid_q <= skid_d;
      head_v_q <= head_v_d;
      skid_v_q <= skid_v_d;
      pkt_ready_q <= pkt_ready_d;
    end
  end

  assign PKT_READY = pkt_ready_q;
  assign OUT_VALID = head_v_q;
  assign OUT_TAG = head_q.tag;
  assign OUT_CHAN = head_q.chan;
  assign OUT_SYNC = head_q.sync;
  assign OUT_CTX_HIT = head_q.hit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ptr_ro;
    @(posedge CLK) disable iff (!RST_N)
      (access & PWRITE & is_ptr & ~PTR_LOAD) |=> $stable(ptr_q[0]);
  endproperty
  a_ptr_ro: assert property (p_ptr_ro)
    else $error("pointer changed by a software write");

  property p_match_read;
    @(posedge CLK) disable iff (!RST_N)
      (access & ~PWRITE & is_match & ~$past(PTR_LOAD)) |->
        PRDATA == (match_q[ctx] & `IRX_MATCH_WMASK);
  endproperty
  a_match_read: assert property (p_match_read)
    else $error("match read returned wrong context");

  property p_push_out;
    @(posedge CLK) disable iff (!RST_N)
      push |=> OUT_VALID;
  endproperty
  a_push_out: assert property (p_push_out)
    else $error("accepted packet not presented");

  property p_accept_tag_three;
    @(posedge CLK) disable iff (!RST_N)
      (acc & hit_vec[0] & PKT_TAG == `IRX_TAG_THREE) |->
        match_q[0][`IRX_ACCEPT_TAG_THREE_BIT];
  endproperty
  a_accept_tag_three: assert property (p_accept_tag_three)
    else $error("tag 11 accepted while disabled");

  property p_accept_tag_two;
    @(posedge CLK) disable iff (!RST_N)
      (acc & hit_vec[0] & PKT_TAG == `IRX_TAG_TWO) |->
        match_q[0][`IRX_ACCEPT_TAG_TWO_BIT];
  endproperty
  a_accept_tag_two: assert property (p_accept_tag_two)
    else $error("tag 10 accepted while disabled");

  property p_accept_tag_one;
    @(posedge CLK) disable iff (!RST_N)
      (acc & hit_vec[0] & PKT_TAG == `IRX_TAG_ONE) |->
        match_q[0][`IRX_ACCEPT_TAG_ONE_BIT];
  endproperty
  a_accept_tag_one: assert property (p_accept_tag_one)
    else $error("tag 01 accepted while disabled");

  property p_accept_tag_zero;
    @(posedge CLK) disable iff (!RST_N)
      (acc & hit_vec[3] & PKT_TAG == `IRX_TAG_ZERO) |->
        match_q[3][`IRX_ACCEPT_TAG_ZERO_BIT];
  endproperty
  a_accept_tag_zero: assert property (p_accept_tag_zero)
    else $error("tag 00 accepted while disabled");

  property p_cycle_start;
    @(posedge CLK) disable iff (!RST_N)
      (CYC_MATCH_EN[1] &
       CYC_TIME == match_q[1][`IRX_CYC_MSB:`IRX_CYC_LSB])
        ##1 CYC_MATCH_EN[1] |-> started_q[1];
  endproperty
  a_cycle_start: assert property (p_cycle_start)
    else $error("context did not open on its start cycle");

  property p_sync_wait;
    @(posedge CLK) disable iff (!RST_N)
      (hit_vec[2] & SYNC_WAIT[2] & ~seen_q[2]) |->
        PKT_SYNC == match_q[2][`IRX_SYNC_MSB:`IRX_SYNC_LSB];
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("packet passed before sync value");

  property p_accept_tag_one_sync;
    @(posedge CLK) disable iff (!RST_N)
      (hit_vec[3] & match_q[3][`IRX_RSYNC_BIT] &
       PKT_TAG == `IRX_TAG_ONE) |->
        PKT_SYNC[`IRX_SYNC_HI_MSB:`IRX_SYNC_HI_LSB] == `IRX_SYNC_HI_OK;
  endproperty
  a_accept_tag_one_sync: assert property (p_accept_tag_one_sync)
    else $error("tag 01 passed with high sync bits set");

  property p_channel;
    @(posedge CLK) disable iff (!RST_N)
      hit_vec[2] |->
        PKT_CHAN == match_q[2][`IRX_CHAN_MSB:`IRX_CHAN_LSB];
  endproperty
  a_channel: assert property (p_channel)
    else $error("packet of another channel accepted");

  property p_rsvd;
    @(posedge CLK) disable iff (!RST_N)
      (access & PWRITE & is_match) |=> !match_q[ctx][`IRX_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved match bit stored");

endmodule : irx_top

// *** dv/irx_link_model.sv ***
// Purpose: Link receive path that hands packet headers to the block.
// Assumes: One header per go pulse, issued only while valid is low.
// Notes: Idle header lines show the inverse of the last header, so
//   nothing can lean on a stale value.
`timescale 1ns/1ps

module irx_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [11:0] hdr,
  input wire logic ready,
  output logic valid,
  output logic [11:0] bus
);
  logic [11:0] last_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'h0;
      last_q <= 12'h000;
    end else if (go) begin
      valid <= 1'h1;
      last_q <= hdr;
    end else if (valid && ready) begin
      valid <= 1'h0;
    end
  end

  assign bus = valid ? last_q : ~last_q;
endmodule : irx_link_model

// *** dv/iso_rx_context_pointer_match_tb.sv ***
// Purpose: Self-checking bench for the receive pointer and match block.
// Assumes: Zero-wait APB slave; packets come from the link model.
// Notes: Every wait is bounded and a spent bound fails the run.
`timescale 1ns/1ps

module iso_rx_context_pointer_match_tb;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, ptr_load = 1'h0, go = 1'h0, out_ready = 1'h1;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, ptr_addr = 32'h0, prdata, rd;
  logic [1:0] ptr_ctx = 2'h0, out_tag;
  logic [3:0] cyc_en = 4'h0, sync_wait = 4'h0, out_sync, out_hit;
  logic [14:0] cyc_time = 15'h0000;
  logic [11:0] hdr = 12'h000, pbus;
  logic [5:0] out_chan;
  logic pready, pslverr, pkt_valid, pkt_ready, out_valid, er;
  int failures = 0, comparisons = 0;

  always #2 clk = ~clk;

  irx_link_model link (.clk(clk), .rst_n(rst_n), .go(go), .hdr(hdr),
    .ready(pkt_ready), .valid(pkt_valid), .bus(pbus));

  irx_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PTR_LOAD(ptr_load),
    .PTR_CTX(ptr_ctx), .PTR_ADDR(ptr_addr), .CYC_MATCH_EN(cyc_en),
    .CYC_TIME(cyc_time), .SYNC_WAIT(sync_wait), .PKT_VALID(pkt_valid),
    .PKT_READY(pkt_ready), .PKT_TAG(pbus[11:10]), .PKT_CHAN(pbus[9:4]),
    .PKT_SYNC(pbus[3:0]), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .OUT_TAG(out_tag), .OUT_CHAN(out_chan), .OUT_SYNC(out_sync),
    .OUT_CTX_HIT(out_hit));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task results;
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    n = 0;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      failures++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task send(input logic [11:0] h);
    int n;
    go <= 1'h1;
    hdr <= h;
    n = 0;
    do begin
      @(posedge clk);
      go <= 1'h0;
      n++;
    end while (!(pkt_valid && pkt_ready) && n < 20);
    if (!(pkt_valid && pkt_ready)) begin
      failures++;
      results();
    end
  endtask : send

  // The answer lands on the same edge as the take and is read one step later.
  task pkt(input logic [11:0] h, input logic [3:0] hit);
    send(h);
    #1;
    if (hit == 4'h0) chk({31'h0, out_valid}, 32'h0);
    else chk({15'h0, out_valid, out_tag, out_chan, out_sync, out_hit},
             {15'h0, 1'h1, h, hit});
    @(posedge clk);
  endtask : pkt

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    for (int n = 0; n < 4; n++) begin
      apb(1'h0, 16'h040C + 16'(32 * n), 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, 16'h410C + 16'(32 * n), 32'hFFFF_FFFF);
      apb(1'h0, 16'h410C + 16'(32 * n), 32'h0);
      chk(rd, 32'hF7FF_FF7F);
      apb(1'h1, 16'h410C + 16'(32 * n), 32'h0);
    end
    apb(1'h0, 16'h0000, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_regs

  task t_ptr;
    for (int n = 0; n < 4; n++) begin
      ptr_load <= 1'h1;
      ptr_ctx <= 2'(n);
      ptr_addr <= 32'hA000_0010 + n;
      @(posedge clk);
      ptr_load <= 1'h0;
      apb(1'h1, 16'h040C + 16'(32 * n), 32'h5555_5555);
    end
    for (int n = 0; n < 4; n++) begin
      apb(1'h0, 16'h040C + 16'(32 * n), 32'h0);
      chk(rd, 32'hA000_0010 + n);
    end
  endtask : t_ptr

  task t_tags;
    for (int t = 0; t < 4; t++) begin
      apb(1'h1, 16'h410C, (32'h1 << (28 + t)) | 32'h15);
      for (int u = 0; u < 4; u++)
        pkt({2'(u), 6'h15, 4'h0}, (u == t) ? 4'h1 : 4'h0);
      pkt({2'(t), 6'h14, 4'h0}, 4'h0);
    end
    apb(1'h1, 16'h410C, 32'h0);
  endtask : t_tags

  task t_sync1;
    apb(1'h1, 16'h416C, 32'h3000_0049);
    pkt({2'h1, 6'h09, 4'h4}, 4'h0);
    pkt({2'h1, 6'h09, 4'h3}, 4'h8);
    pkt({2'h0, 6'h09, 4'hC}, 4'h8);
    apb(1'h1, 16'h416C, 32'h0);
  endtask : t_sync1

  task t_cycle;
    apb(1'h1, 16'h412C, 32'h805A_3002);
    cyc_en <= 4'h2;
    cyc_time <= 15'h05A2;
    pkt({2'h3, 6'h02, 4'h0}, 4'h0);
    cyc_time <= 15'h05A3;
    @(posedge clk);
    cyc_time <= 15'h05A4;
    pkt({2'h3, 6'h02, 4'h0}, 4'h2);
    cyc_en <= 4'h0;
    apb(1'h1, 16'h412C, 32'h0);
  endtask : t_cycle

  task t_wait;
    apb(1'h1, 16'h414C, 32'h1000_0507);
    sync_wait <= 4'h4;
    pkt({2'h0, 6'h07, 4'h3}, 4'h0);
    pkt({2'h0, 6'h07, 4'h5}, 4'h4);
    pkt({2'h0, 6'h07, 4'h3}, 4'h4);
    sync_wait <= 4'h0;
    apb(1'h1, 16'h414C, 32'h0);
  endtask : t_wait

  // A stalled receiver must lose nothing and keep the order.
  task t_buffer;
    int n;
    apb(1'h1, 16'h410C, 32'hF000_0001);
    out_ready <= 1'h0;
    send({2'h0, 6'h01, 4'h1});
    send({2'h1, 6'h01, 4'h2});
    @(posedge clk);
    #1;
    chk({31'h0, pkt_ready}, 32'h0);
    @(posedge clk);
    out_ready <= 1'h1;
    go <= 1'h1;
    hdr <= {2'h2, 6'h01, 4'h3};
    for (int k = 1; k < 4; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        go <= 1'h0;
        n++;
      end while (!(out_valid && out_ready) && n < 20);
      if (!(out_valid && out_ready)) begin
        failures++;
        results();
      end
      chk({28'h0, out_sync}, 32'(k));
    end
    apb(1'h1, 16'h410C, 32'h0);
  endtask : t_buffer

  // A reset in mid-run must clear loaded registers and close the port.
  task t_reset;
    apb(1'h1, 16'h410C, 32'hF000_0001);
    ptr_load <= 1'h1;
    ptr_ctx <= 2'h0;
    ptr_addr <= 32'h1234_5678;
    @(posedge clk);
    ptr_load <= 1'h0;
    rst_n <= 1'h0;
    #1;
    chk({31'h0, pkt_ready}, 32'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    #1;
    chk({31'h0, pkt_ready}, 32'h1);
    @(posedge clk);
    apb(1'h0, 16'h040C, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 16'h410C, 32'h0);
    chk(rd, 32'h0);
    pkt({2'h0, 6'h01, 4'h1}, 4'h0);
  endtask : t_reset

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_ptr();
    t_tags();
    t_sync1();
    t_cycle();
    t_wait();
    t_buffer();
    t_reset();
    results();
  end
endmodule : iso_rx_context_pointer_match_tb
